/* rtl/huffman_params.svh */
/*
 Constants for the serial variable-length code store.
 Assumes one system clock; included by the package and the top module.
*/
`ifndef HUFFMAN_PARAMS_SVH
`define HUFFMAN_PARAMS_SVH

`define SRG_RESET_VALUE   8'h01
`define SRG_TAP_A         7
`define SRG_TAP_B         3
`define SRG_TAP_C         2
`define SRG_TAP_D         1
`define CODE_COUNT        6'h22
`define CODE_LONG_FIRST   6'h20
`define CODE_MIN_LEN      4'h2
`define CODE_MAX_LEN      4'h8
`define COUNT_RESET_VALUE 4'h0

`endif

/* rtl/huffman_pkg.sv */
/*
 Types for the serial variable-length code store.
 Assumes the constants header sits beside it.
*/
`include "huffman_params.svh"

package huffman_pkg;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_WAIT   = 4'h2,
		ST_SEARCH = 4'h4,
		ST_SHIFT  = 4'h8
	} ctrl_state_t;

	typedef struct packed {
		logic [3:0] len;
		logic [7:0] bits;
	} code_entry_t;

	typedef struct packed {
		logic data;
		logic valid;
	} serial_bit_t;

endpackage

/* rtl/huffman_code_srg_store.sv */
/*
 Addressable variable-length code store built on an eight-stage maximal-length
 shift register generator. Assumes a processor output port that drives a six-bit
 address with a write strobe, and a receiver sampling one bit per valid cycle.
*/
`timescale 1ns/1ns
`include "huffman_params.svh"

module huffman_code_srg_store #(
	parameter int ADDR_W = 6
) (
	// Clock and reset
	input  wire logic                      CLK,
	input  wire logic                      RESETN,
	// Processor output port and serial output to the receiver
	input  wire logic [ADDR_W-1:0]         CODE_ADDRESS,
	input  wire logic                      ADDRESS_WRITE_STROBE,
	output huffman_pkg::serial_bit_t       SERIAL_OUT,
	// Status
	output logic                           READY,
	output logic                           CODE_MATCH_FOUND
);
	import huffman_pkg::*;

	// ==========================================================
	// Code table
	function automatic code_entry_t code_lookup(input logic [5:0] a);
		code_entry_t e;
		e = '{len: 4'h0, bits: 8'h00};
		unique case (a)
			6'h00: e = '{4'h2, 8'h00};
			6'h01: e = '{4'h3, 8'h05};
			6'h02: e = '{4'h3, 8'h06};
			6'h03: e = '{4'h4, 8'h05};
			6'h04: e = '{4'h4, 8'h06};
			6'h05: e = '{4'h4, 8'h08};
			6'h06: e = '{4'h5, 8'h13};
			6'h07: e = '{4'h5, 8'h1d};
			6'h08: e = '{4'h6, 8'h11};
			6'h09: e = '{4'h6, 8'h12};
			6'h0a: e = '{4'h6, 8'h1c};
			6'h0b: e = '{4'h6, 8'h1e};
			6'h0c: e = '{4'h6, 8'h3e};
			6'h0d: e = '{4'h6, 8'h3c};
			6'h0e: e = '{4'h6, 8'h3d};
			6'h0f: e = '{4'h7, 8'h21};
			6'h10: e = '{4'h7, 8'h26};
			6'h11: e = '{4'h7, 8'h27};
			6'h12: e = '{4'h7, 8'h3a};
			6'h13: e = '{4'h7, 8'h3b};
			6'h14: e = '{4'h7, 8'h3f};
			6'h15: e = '{4'h7, 8'h3e};
			6'h16: e = '{4'h7, 8'h48};
			6'h17: e = '{4'h7, 8'h49};
			6'h18: e = '{4'h7, 8'h4a};
			6'h19: e = '{4'h7, 8'h4b};
			6'h1a: e = '{4'h7, 8'h70};
			6'h1b: e = '{4'h7, 8'h61};
			6'h1c: e = '{4'h7, 8'h70};
			6'h1d: e = '{4'h7, 8'h71};
			6'h1e: e = '{4'h7, 8'h7f};
			6'h1f: e = '{4'h7, 8'h7e};
			6'h20: e = '{4'h8, 8'h40};
			6'h21: e = '{4'h8, 8'h41};
			default: e = '{4'h0, 8'h00};
		endcase
		return e;
	endfunction

	// Oldest len bits of the generator, oldest stage in the top position
	function automatic logic [7:0] srg_window(input logic [7:0] s, input logic [3:0] len);
		return 8'(s >> (4'h8 - len));
	endfunction

	// ==========================================================
	// Input synchronisers
	logic [2:0]        strb_s_q;
	logic [2:0]        strb_s_d;
	logic              strb_lvl_q;
	logic              strb_lvl_d;
	logic [ADDR_W-1:0] addr_s0_q, addr_s1_q, addr_s2_q;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;

	always_comb begin
		strb_s_d   = {strb_s_q[1:0], ADDRESS_WRITE_STROBE};
		strb_lvl_d = (strb_s_q[1] == strb_s_q[2]) ? strb_s_q[2] : strb_lvl_q;
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			strb_s_q   <= 3'h0;
			strb_lvl_q <= 1'b0;
			addr_s0_q  <= '0;
			addr_s1_q  <= '0;
			addr_s2_q  <= '0;
		end else begin
			strb_s_q   <= strb_s_d;
			strb_lvl_q <= strb_lvl_d;
			addr_s0_q  <= CODE_ADDRESS;
			addr_s1_q  <= addr_s0_q;
			addr_s2_q  <= addr_s1_q;
		end
	end

	// ==========================================================
	// Generator and controller
	ctrl_state_t state_q;
	ctrl_state_t state_d;
	logic [7:0]  srg_q;
	logic [7:0]  srg_d;
	logic [3:0]  count_q;
	logic [3:0]  count_d;
	logic        feedback;
	logic        srg_adv;
	logic        match;
	code_entry_t entry;
	serial_bit_t out_d;
	logic        found_d;
	logic        ready_d;

	assign entry    = code_lookup(addr_q);
	assign feedback = srg_q[`SRG_TAP_A] ^ srg_q[`SRG_TAP_B]
	                ^ srg_q[`SRG_TAP_C] ^ srg_q[`SRG_TAP_D];
	assign match    = (state_q == ST_SEARCH) && (entry.len != 4'h0)
	                && (srg_window(srg_q, entry.len) == entry.bits);

	always_comb begin
		state_d = state_q;
		count_d = count_q;
		addr_d  = addr_q;
		out_d   = '{data: 1'b0, valid: 1'b0};
		found_d = 1'b0;
		srg_adv = 1'b1;
		unique case (state_q)
			ST_IDLE: begin
				if (strb_lvl_q)
					state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (addr_s1_q == addr_s2_q)
					addr_d = addr_s2_q;
				if (!strb_lvl_q)
					state_d = ST_SEARCH;
			end
			ST_SEARCH: begin
				if (entry.len == 4'h0) begin
					state_d = ST_IDLE;
				end else if (match) begin
					count_d = entry.len;
					srg_adv = 1'b0;
					found_d = 1'b1;
					state_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				out_d   = '{data: srg_q[7], valid: 1'b1};
				count_d = 4'(count_q - 4'h1);
				if (count_q == 4'h1)
					state_d = ST_IDLE;
			end
		endcase
		srg_d = srg_adv ? {srg_q[6:0], feedback} : srg_q;
		ready_d = (state_d == ST_IDLE);
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state_q          <= ST_IDLE;
			srg_q            <= `SRG_RESET_VALUE;
			count_q          <= `COUNT_RESET_VALUE;
			addr_q           <= '0;
			SERIAL_OUT       <= '{data: 1'b0, valid: 1'b0};
			READY            <= 1'b1;
			CODE_MATCH_FOUND <= 1'b0;
		end else begin
			state_q          <= state_d;
			srg_q            <= srg_d;
			count_q          <= count_d;
			addr_q           <= addr_d;
			SERIAL_OUT       <= out_d;
			READY            <= ready_d;
			CODE_MATCH_FOUND <= found_d;
		end
	end

	// ==========================================================
	// Checks
	chk_srg_nonzero: assert property (@(posedge CLK) disable iff (!RESETN)
		srg_q != 8'h00) else $error("generator reached all zeros");

	chk_srg_shift: assert property (@(posedge CLK) disable iff (!RESETN)
		RESETN && srg_adv |=> srg_q[7:1] == $past(srg_q[6:0]))
		else $error("stages did not shift");

	chk_srg_feedback: assert property (@(posedge CLK) disable iff (!RESETN)
		RESETN && srg_adv |=> srg_q[0] == ($past(srg_q[7]) ^ $past(srg_q[3])
		^ $past(srg_q[2]) ^ $past(srg_q[1]))) else $error("wrong feedback");

	chk_match_freeze: assert property (@(posedge CLK) disable iff (!RESETN)
		match |=> state_q == ST_SHIFT && srg_q == $past(srg_q) && CODE_MATCH_FOUND
		&& count_q == $past(entry.len)) else $error("match not held");

	chk_bit_order: assert property (@(posedge CLK) disable iff (!RESETN)
		state_q == ST_SHIFT |=> SERIAL_OUT.valid && SERIAL_OUT.data == $past(srg_q[7]))
		else $error("bit out of order");

	chk_shift_end: assert property (@(posedge CLK) disable iff (!RESETN)
		state_q == ST_SHIFT && count_q == 4'h1 |=> state_q == ST_IDLE
		##1 !SERIAL_OUT.valid) else $error("shift did not end");

	chk_strobe_wait: assert property (@(posedge CLK) disable iff (!RESETN)
		state_q == ST_WAIT && strb_lvl_q |=> state_q == ST_WAIT)
		else $error("search before strobe fell");

	chk_ready_idle: assert property (@(posedge CLK) disable iff (!RESETN)
		READY == (state_q == ST_IDLE)) else $error("ready mismatch");

	chk_len_range: assert property (@(posedge CLK) disable iff (!RESETN)
		addr_q < `CODE_COUNT |-> entry.len >= `CODE_MIN_LEN && entry.len <= `CODE_MAX_LEN)
		else $error("code length out of range");

	chk_long_pair: assert property (@(posedge CLK) disable iff (!RESETN)
		addr_q < `CODE_COUNT |-> (entry.len == `CODE_MAX_LEN) == (addr_q >= `CODE_LONG_FIRST))
		else $error("longest codes not the final pair");

	cov_match: cover property (@(posedge CLK) disable iff (!RESETN) match);
	cov_long_code: cover property (@(posedge CLK) disable iff (!RESETN)
		match && entry.len == `CODE_MAX_LEN);
	cov_bad_addr: cover property (@(posedge CLK) disable iff (!RESETN)
		state_q == ST_SEARCH && entry.len == 4'h0);

endmodule

/* test/huffman_partner.sv */
/*
 Partner model: processor output port and synchronous serial receiver.
 Assumes the store's clock and reset; the bench calls write_address.
*/
`timescale 1ns/1ns
// ==========
// Partner model
module huffman_partner (
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                RESETN,
	// Serial receiver side
	input  huffman_pkg::serial_bit_t SERIAL_OUT,
	output logic [7:0]               rx_bits_q,
	output logic [7:0]               rx_count_q,
	// Processor output port
	output logic [5:0]               CODE_ADDRESS,
	output logic                     ADDRESS_WRITE_STROBE
);
	import huffman_pkg::*;
	initial begin
		CODE_ADDRESS = 6'h00;
		ADDRESS_WRITE_STROBE = 1'b0;
	end
	// Address held from strobe rise to well past its fall
	task write_address(input logic [5:0] addr);
		@(posedge CLK);
		CODE_ADDRESS <= addr;
		ADDRESS_WRITE_STROBE <= 1'b1;
		repeat (6) @(posedge CLK);
		ADDRESS_WRITE_STROBE <= 1'b0;
		repeat (6) @(posedge CLK);
		CODE_ADDRESS <= ~addr;
	endtask
	// Receiver shifts in one bit per data clock
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			rx_bits_q <= 8'h00;
			rx_count_q <= 8'h00;
		end else if (SERIAL_OUT.valid) begin
			rx_bits_q <= {rx_bits_q[6:0], SERIAL_OUT.data};
			rx_count_q <= rx_count_q + 8'h01;
		end
	end
endmodule

/* test/huffman_code_srg_store_bench.sv */
/*
 Self-checking bench for the code store.
 Assumes the partner model drives the port and collects the serial bits.
*/
`timescale 1ns/1ns
// ==========
// Bench
module huffman_code_srg_store_bench;
	import huffman_pkg::*;
	logic        CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic [5:0]  code_address;
	logic        strobe;
	serial_bit_t serial_out;
	logic        ready;
	logic        match;
	logic [7:0]  rx_bits;
	logic [7:0]  rx_count;
	logic [7:0]  hit_q;
	int          mismatches = 0;
	int          compares = 0;
	logic [11:0] tbl [0:33] = '{12'h200, 12'h305, 12'h306, 12'h405, 12'h406, 12'h408,
		12'h513, 12'h51d, 12'h611, 12'h612, 12'h61c, 12'h61e, 12'h63e, 12'h63c,
		12'h63d, 12'h721, 12'h726, 12'h727, 12'h73a, 12'h73b, 12'h73f, 12'h73e,
		12'h748, 12'h749, 12'h74a, 12'h74b, 12'h770, 12'h761, 12'h770, 12'h771,
		12'h77f, 12'h77e, 12'h840, 12'h841};
	always #20 CLK = ~CLK;
	always_ff @(posedge CLK) begin
		hit_q <= !RESETN ? 8'h00 : hit_q + {7'h00, match};
	end
	huffman_code_srg_store i_huffman_code_srg_store (.CLK(CLK), .RESETN(RESETN),
		.CODE_ADDRESS(code_address), .ADDRESS_WRITE_STROBE(strobe),
		.SERIAL_OUT(serial_out), .READY(ready), .CODE_MATCH_FOUND(match));
	huffman_partner i_huffman_partner (.CLK(CLK), .RESETN(RESETN), .SERIAL_OUT(serial_out),
		.rx_bits_q(rx_bits), .rx_count_q(rx_count), .CODE_ADDRESS(code_address),
		.ADDRESS_WRITE_STROBE(strobe));
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task summarize();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One address written, code collected and compared; len 0 means unmapped
	task run_code(input logic [5:0] a, input logic [3:0] len, input logic [7:0] code);
		logic [7:0] c0;
		logic [7:0] h0;
		logic [7:0] m;
		int         n;
		c0 = rx_count;
		h0 = hit_q;
		m = ~(8'hff << len);
		i_huffman_partner.write_address(a);
		@(negedge CLK);
		check("busy", {7'h00, ready}, (len == 4'h0) ? 8'h01 : 8'h00);
		n = 0;
		while (n < 600 && !((hit_q != h0 || len == 4'h0) && ready === 1'b1)) begin
			@(negedge CLK);
			n++;
		end
		if (n == 600) begin
			mismatches++;
			summarize();
		end
		repeat (2) @(negedge CLK);
		check("pulses", hit_q - h0, (len == 4'h0) ? 8'h00 : 8'h01);
		check("length", rx_count - c0, {4'h0, len});
		check("bits", rx_bits & m, code);
	endtask
	// Outputs while reset is held
	task check_reset();
		repeat (3) @(negedge CLK);
		check("ready", {7'h00, ready}, 8'h01);
		check("valid", {7'h00, serial_out.valid}, 8'h00);
	endtask
	// Every stored code in address order
	task run_table();
		for (int i = 0; i < 34; i++) begin
			run_code(6'(i), tbl[i][11:8], tbl[i][7:0]);
		end
	endtask
	// Addresses past the code set give no bits and no pulse
	task run_unmapped();
		run_code(6'h22, 4'h0, 8'h00);
		run_code(6'h3f, 4'h0, 8'h00);
	endtask
	// A long code again after an unmapped search
	task run_repeat();
		run_code(6'h21, 4'h8, 8'h41);
	endtask
	initial begin
		check_reset();
		repeat (3) @(posedge CLK);
		RESETN <= 1'b1;
		run_table();
		run_unmapped();
		run_repeat();
		summarize();
	end
endmodule
